// ===== rsc_ext_model.sv
module rsc_ext_model
   import rsc_pkg::*;
#(
   parameter int PIN_MIN = 210,
   parameter int OSC_DLY = 40
)
(
   input wire logic mclk,
   input wire logic sysClkEn,
   input wire logic sysResetOut,
   input wire logic pinLowReq,
   input wire logic [7:0] irqLevel,
   output logic resetPinIn,
   output logic oscRunning,
   output logic [7:0] intReq
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Pin source and oscillator
   // ----------------------------------------
   int pinCnt = 0;
   int oscCnt = 0;
   initial begin
      resetPinIn = 1'b1;
      oscRunning = 1'b0;
      intReq = 8'h00;
   end
   always @(posedge mclk) begin
      intReq <= irqLevel;
      if (pinLowReq || (!resetPinIn && pinCnt < PIN_MIN)) begin
         resetPinIn <= 1'b0;
         pinCnt <= pinCnt + 1;
      end else begin
         resetPinIn <= 1'b1;
         pinCnt <= 0;
      end
      // Restarts only once a reset or any raised interrupt request, masked or not, asks
      if (sysClkEn) begin
         oscCnt <= 0;
      end else if (sysResetOut || |intReq) begin
         oscCnt <= oscCnt + 1;
      end
      oscRunning <= sysClkEn || oscCnt >= OSC_DLY;
   end
endmodule : rsc_ext_model

// ===== rsc_map.svh
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define RSC_ADDR_W 4
`define RSC_OFS_CTRL 4'h0
`define RSC_OFS_SETTLE 4'h4
`define RSC_OFS_STATUS 4'h8

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RSC_CTRL_IDLE 0
`define RSC_CTRL_STOP 1
`define RSC_CTRL_XTAL 2
`define RSC_SETTLE_W 2
`define RSC_ST_STATE_LO 0
`define RSC_ST_STATE_HI 3
`define RSC_ST_CAUSE_LO 4
`define RSC_ST_CAUSE_HI 7

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RSC_CTRL_RST 1'h0
`define RSC_SETTLE_RST 2'h0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define RSC_CLK_PERIOD_NS 10
`define RSC_STOP_FIX_NS 34000
`define RSC_PIN_MIN_NS 2000
`define RSC_OPT_READ_NS 100
`define RSC_CYC(ns) (((ns) + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_TMR_W 16
`define RSC_SETTLE_CYC0 16'h0100
`define RSC_SETTLE_CYC1 16'h0200
`define RSC_SETTLE_CYC2 16'h0400
`define RSC_SETTLE_CYC3 16'h0800

`endif

// ===== rsc_pkg.sv
package rsc_pkg;

   typedef enum logic [3:0] {
      RSC_RESET = 4'h0,
      RSC_PIN_HOLD = 4'h1,
      RSC_RST_OSC = 4'h2,
      RSC_OPT_READ = 4'h3,
      RSC_OPT_SETTLE = 4'h4,
      RSC_RUN = 4'h5,
      RSC_IDLE = 4'h6,
      RSC_STOP = 4'h7,
      RSC_STOP_OSC = 4'h8,
      RSC_STOP_FIX = 4'h9,
      RSC_STOP_SETTLE = 4'ha
   } rsc_state_t;

   typedef struct packed {
      logic resetPinInputPort;
      logic [1:0] settleCode;
   } rsc_opt_t;

   typedef struct packed {
      logic powerOnClear;
      logic lowVoltageDetector;
      logic watchdog;
      logic pin;
   } rsc_cause_t;

endpackage : rsc_pkg

// ===== rsc_standby_reset.sv
// Function
// - The deep-sleep exit wait is counted only after the oscillator reports that it runs, for reset and interrupt exits alike.
// - The settle wait after reset release uses the option byte value, not the settle-select register.
// - Idle or deep sleep is left at once, or never entered, while any request flag is set with its mask clear.
// - A deep-sleep exit holds operation for a fixed typical interval before normal operation resumes.
// - With a crystal or ceramic resonator the settle-select wait is added after the fixed interval.
// - While any reset is asserted both the system clock and the low-speed oscillator are stopped.
// - With the reset pin used as an input port, a low pin after an internal reset release and before the option byte is read again still resets.
// - A reset entered that way holds until the pin goes high.
// - The low-voltage detector is not reset by its own internal reset.
// - A watchdog overflow reset also resets the watchdog.
//
// The implementer's own choices: the strobed register port and the register addresses.
`include "rsc_map.svh"

module rsc_standby_reset
   import rsc_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [`RSC_ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire logic [7:0] intReq,
   input wire logic [7:0] intMask,
   input wire logic resetPinIn,
   input wire logic powerOnClearReq,
   input wire logic lowVoltageDetectorReq,
   input wire logic watchdogReq,
   input wire logic oscRunning,
   input wire rsc_opt_t optByte,
   output logic sysClkEn,
   output logic lowSpeedOscEn,
   output logic cpuRun,
   output logic sysResetOut,
   output logic lowVoltageDetectorRst,
   output logic watchdogRst
);

   // ------------------------------------------------------------
   // State and registers
   // ------------------------------------------------------------
   rsc_state_t state_r;
   rsc_state_t state_nxt;
   rsc_cause_t cause_r;
   rsc_cause_t cause_nxt;
   rsc_opt_t opt_r;
   rsc_opt_t opt_nxt;
   logic xtal_r;
   logic xtal_nxt;
   logic [`RSC_SETTLE_W-1:0] settle_r;
   logic [`RSC_SETTLE_W-1:0] settle_nxt;
   logic [`RSC_TMR_W-1:0] pinCnt_r;
   logic [`RSC_TMR_W-1:0] pinCnt_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic outRst_r;
   logic outRst_nxt;
   logic lviRst_r;
   logic lviRst_nxt;
   logic wdtRst_r;
   logic wdtRst_nxt;
   logic clkEn_r;
   logic clkEn_nxt;
   logic lsEn_r;
   logic lsEn_nxt;
   logic run_r;
   logic run_nxt;

   logic tmrLoad;
   logic [`RSC_TMR_W-1:0] tmrVal;
   logic tmrDone;
   logic wakePending;
   logic internalReq;
   logic pinLow;
   logic pinQualified;
   logic wrCtrl;
   logic idleReq;
   logic stopReq;

   // ------------------------------------------------------------
   // Wait timer
   // ------------------------------------------------------------
   rsc_timer u_timer (
      .mclk(mclk),
      .arst_n(arst_n),
      .load(tmrLoad),
      .loadVal(tmrVal),
      .done(tmrDone)
   );

   function automatic logic [`RSC_TMR_W-1:0] settleCycles(input logic [`RSC_SETTLE_W-1:0] code);
      logic [`RSC_TMR_W-1:0] v;
      case (code)
         2'h0: v = `RSC_SETTLE_CYC0;
         2'h1: v = `RSC_SETTLE_CYC1;
         2'h2: v = `RSC_SETTLE_CYC2;
         default: v = `RSC_SETTLE_CYC3;
      endcase
      return v;
   endfunction : settleCycles

   // ------------------------------------------------------------
   // Request decode
   // ------------------------------------------------------------
   // unmasked wake
   assign wakePending = |(intReq & ~intMask);
   assign internalReq = powerOnClearReq | lowVoltageDetectorReq | watchdogReq;
   assign pinLow = !resetPinIn;
   assign wrCtrl = regWr && (regAddr == `RSC_OFS_CTRL);
   assign idleReq = wrCtrl && regWdata[`RSC_CTRL_IDLE];
   assign stopReq = wrCtrl && regWdata[`RSC_CTRL_STOP];

   // ------------------------------------------------------------
   // Reset pin filter
   // ------------------------------------------------------------
   // Glitches shorter than the minimum low time are ignored
   always_comb begin
      pinCnt_nxt = pinLow ? pinCnt_r : '0;
      if (pinLow && (pinCnt_r != `RSC_TMR_W'(`RSC_CYC(`RSC_PIN_MIN_NS)))) begin
         pinCnt_nxt = pinCnt_r + 1'b1;
      end
   end
   assign pinQualified = (pinCnt_r == `RSC_TMR_W'(`RSC_CYC(`RSC_PIN_MIN_NS)));

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      cause_nxt = cause_r;
      opt_nxt = opt_r;
      tmrLoad = 1'b0;
      tmrVal = '0;
      case (state_r)
         RSC_RESET: begin
            if (!internalReq) begin
               state_nxt = pinLow ? RSC_PIN_HOLD : RSC_RST_OSC;
            end
         end
         RSC_PIN_HOLD: begin
            if (resetPinIn) begin
               state_nxt = RSC_RST_OSC;
            end
         end
         RSC_RST_OSC: begin
            if (oscRunning) begin
               state_nxt = RSC_OPT_READ;
               tmrLoad = 1'b1;
               tmrVal = `RSC_TMR_W'(`RSC_CYC(`RSC_OPT_READ_NS));
            end
         end
         RSC_OPT_READ: begin
            if (tmrDone) begin
               opt_nxt = optByte;
               state_nxt = RSC_OPT_SETTLE;
               tmrLoad = 1'b1;
               tmrVal = settleCycles(optByte.settleCode);
            end
         end
         RSC_OPT_SETTLE: begin
            if (tmrDone) begin
               state_nxt = RSC_RUN;
            end
         end
         RSC_RUN: begin
            if (!wakePending) begin
               if (stopReq) begin
                  state_nxt = RSC_STOP;
               end else if (idleReq) begin
                  state_nxt = RSC_IDLE;
               end
            end
         end
         RSC_IDLE: begin
            if (wakePending) begin
               state_nxt = RSC_RUN;
            end
         end
         RSC_STOP: begin
            if (wakePending) begin
               state_nxt = RSC_STOP_OSC;
            end
         end
         RSC_STOP_OSC: begin
            if (oscRunning) begin
               state_nxt = RSC_STOP_FIX;
               tmrLoad = 1'b1;
               tmrVal = `RSC_TMR_W'(`RSC_CYC(`RSC_STOP_FIX_NS));
            end
         end
         RSC_STOP_FIX: begin
            if (tmrDone) begin
               if (xtal_r) begin
                  state_nxt = RSC_STOP_SETTLE;
                  tmrLoad = 1'b1;
                  tmrVal = settleCycles(settle_r);
               end else begin
                  state_nxt = RSC_RUN;
               end
            end
         end
         RSC_STOP_SETTLE: begin
            if (tmrDone) begin
               state_nxt = RSC_RUN;
            end
         end
         default: begin
            state_nxt = RSC_RESET;
         end
      endcase
      // Reset entry overrides every state
      if (internalReq) begin
         state_nxt = RSC_RESET;
         cause_nxt = '0;
         cause_nxt.powerOnClear = powerOnClearReq;
         cause_nxt.lowVoltageDetector = lowVoltageDetectorReq;
         cause_nxt.watchdog = watchdogReq;
      end else if (pinLow && (state_r == RSC_RST_OSC || state_r == RSC_OPT_READ)) begin
         state_nxt = RSC_PIN_HOLD;
         cause_nxt = '0;
         cause_nxt.pin = 1'b1;
      end else if (pinQualified && !opt_r.resetPinInputPort && state_r != RSC_PIN_HOLD) begin
         state_nxt = RSC_PIN_HOLD;
         cause_nxt = '0;
         cause_nxt.pin = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Outputs and register file
   // ------------------------------------------------------------
   always_comb begin
      logic inReset;
      inReset = 1'b0;
      inReset = (state_nxt == RSC_RESET) || (state_nxt == RSC_PIN_HOLD);
      outRst_nxt = inReset;
      clkEn_nxt = !inReset && (state_nxt != RSC_STOP) && (state_nxt != RSC_STOP_OSC);
      lsEn_nxt = !inReset;
      // Registered so the run flag never glitches
      run_nxt = (state_nxt == RSC_RUN);
      lviRst_nxt = inReset && !cause_nxt.lowVoltageDetector;
      wdtRst_nxt = inReset;
      xtal_nxt = xtal_r;
      settle_nxt = settle_r;
      if (inReset) begin
         xtal_nxt = `RSC_CTRL_RST;
         settle_nxt = `RSC_SETTLE_RST;
      end else if (wrCtrl) begin
         xtal_nxt = regWdata[`RSC_CTRL_XTAL];
      end else if (regWr && (regAddr == `RSC_OFS_SETTLE)) begin
         settle_nxt = regWdata[`RSC_SETTLE_W-1:0];
      end
      rdata_nxt = '0;
      if (regRd) begin
         case (regAddr)
            `RSC_OFS_CTRL: rdata_nxt[`RSC_CTRL_XTAL] = xtal_r;
            `RSC_OFS_SETTLE: rdata_nxt[`RSC_SETTLE_W-1:0] = settle_r;
            `RSC_OFS_STATUS: begin
               rdata_nxt[`RSC_ST_STATE_HI:`RSC_ST_STATE_LO] = state_r;
               rdata_nxt[`RSC_ST_CAUSE_HI:`RSC_ST_CAUSE_LO] = cause_r;
            end
            default: rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= RSC_RESET;
         cause_r <= '0;
         opt_r <= '0;
         xtal_r <= `RSC_CTRL_RST;
         settle_r <= `RSC_SETTLE_RST;
         pinCnt_r <= '0;
         rdata_r <= '0;
         outRst_r <= 1'b1;
         lviRst_r <= 1'b1;
         wdtRst_r <= 1'b1;
         clkEn_r <= 1'b0;
         lsEn_r <= 1'b0;
         run_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cause_r <= cause_nxt;
         opt_r <= opt_nxt;
         xtal_r <= xtal_nxt;
         settle_r <= settle_nxt;
         pinCnt_r <= pinCnt_nxt;
         rdata_r <= rdata_nxt;
         outRst_r <= outRst_nxt;
         lviRst_r <= lviRst_nxt;
         wdtRst_r <= wdtRst_nxt;
         clkEn_r <= clkEn_nxt;
         lsEn_r <= lsEn_nxt;
         run_r <= run_nxt;
      end
   end

   assign regRdata = rdata_r;
   assign sysClkEn = clkEn_r;
   assign lowSpeedOscEn = lsEn_r;
   assign cpuRun = run_r;
   assign sysResetOut = outRst_r;
   assign lowVoltageDetectorRst = lviRst_r;
   assign watchdogRst = wdtRst_r;

endmodule : rsc_standby_reset

// ===== rsc_standby_reset_sva.sv
module rsc_standby_reset_sva
   import rsc_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [7:0] intReq,
   input wire logic [7:0] intMask,
   input wire logic resetPinIn,
   input wire logic powerOnClearReq,
   input wire logic lowVoltageDetectorReq,
   input wire logic watchdogReq,
   input wire logic oscRunning,
   input wire logic sysClkEn,
   input wire logic lowSpeedOscEn,
   input wire logic cpuRun,
   input wire logic sysResetOut,
   input wire logic lowVoltageDetectorRst,
   input wire logic watchdogRst
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   logic wake;
   logic noReq;
   logic idleSeen_r;
   logic idleSeen_nxt;
   logic prevRun_r;
   assign wake = |(intReq & ~intMask);
   assign noReq = !powerOnClearReq && !lowVoltageDetectorReq && !watchdogReq;
   // Idle is the only run exit that keeps the clock
   always_comb begin
      idleSeen_nxt = !cpuRun && sysClkEn && !sysResetOut && (idleSeen_r || prevRun_r);
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         idleSeen_r <= 1'b0;
         prevRun_r <= 1'b0;
      end else begin
         idleSeen_r <= idleSeen_nxt;
         prevRun_r <= cpuRun;
      end
   end
   a_reset_clk_off: assert property (sysResetOut |-> !sysClkEn && !lowSpeedOscEn)
      else $error("clock running in reset");
   a_wdt_also_reset: assert property (watchdogReq |-> ##[1:2] (watchdogRst && sysResetOut))
      else $error("watchdog not reset");
   a_lvd_keep_self: assert property (lowVoltageDetectorReq && !watchdogReq && !powerOnClearReq && !sysResetOut
      |-> ##[1:2] (sysResetOut && !lowVoltageDetectorRst)) else $error("detector reset by itself");
   a_wake_no_entry: assert property (cpuRun && wake && resetPinIn && noReq |=> cpuRun)
      else $error("standby entered with wake pending");
   a_idle_wake: assert property (idleSeen_r && wake && noReq |-> ##[1:2] cpuRun)
      else $error("idle not left on wake");
   a_pin_hold_on: assert property (sysResetOut && !resetPinIn |=> sysResetOut)
      else $error("reset dropped with pin low");
   a_reset_release: assert property (sysResetOut && resetPinIn && noReq |-> ##[1:3] !sysResetOut)
      else $error("reset not released");
   a_osc_before_clk: assert property (!sysClkEn && !sysResetOut && !oscRunning |=> !sysClkEn)
      else $error("clock on before oscillation");
endmodule : rsc_standby_reset_sva

bind rsc_standby_reset rsc_standby_reset_sva u_rsc_standby_reset_sva (.mclk, .arst_n, .intReq, .intMask,
   .resetPinIn, .powerOnClearReq, .lowVoltageDetectorReq, .watchdogReq, .oscRunning, .sysClkEn, .lowSpeedOscEn,
   .cpuRun, .sysResetOut, .lowVoltageDetectorRst, .watchdogRst);

// ===== rsc_standby_reset_tb.sv
`include "rsc_map.svh"

module rsc_standby_reset_tb
   import rsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OSC_DLY = 40;
   localparam int FIX = `RSC_CYC(`RSC_STOP_FIX_NS);
   logic mclk, arst_n, regWr, regRd, pinLowReq, resetPinIn, oscRunning;
   logic powerOnClearReq, lowVoltageDetectorReq, watchdogReq;
   logic sysClkEn, lowSpeedOscEn, cpuRun, sysResetOut, lowVoltageDetectorRst, watchdogRst;
   logic [3:0] regAddr;
   logic [31:0] regWdata, regRdata, d;
   logic [7:0] intReq, intMask, irqLevel;
   rsc_opt_t optByte;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   rsc_standby_reset u_rsc_standby_reset (.mclk, .arst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .intReq,
      .intMask, .resetPinIn, .powerOnClearReq, .lowVoltageDetectorReq, .watchdogReq, .oscRunning, .optByte,
      .sysClkEn, .lowSpeedOscEn, .cpuRun, .sysResetOut, .lowVoltageDetectorRst, .watchdogRst);
   rsc_ext_model #(.PIN_MIN(210), .OSC_DLY(OSC_DLY)) u_rsc_ext_model (.mclk, .sysClkEn, .sysResetOut, .pinLowReq,
      .irqLevel, .resetPinIn, .oscRunning, .intReq);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict
   task automatic look(input int k);
      repeat (k) @(posedge mclk);
      @(negedge mclk);
   endtask : look
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      @(negedge mclk);
      d = regRdata;
   endtask : rd
   // Bounded wait, then the elapsed count must fall in the window
   task automatic run_within(input int lo, input int hi);
      int n;
      n = 0;
      while (cpuRun !== 1'b1 && n < 9000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      check({31'h0, n >= lo && n <= hi}, 32'h1);
   endtask : run_within
   task automatic wdt_pulse;
      @(posedge mclk);
      watchdogReq <= 1'b1;
      look(3);
      check({watchdogRst, lowVoltageDetectorRst, sysResetOut, sysClkEn, lowSpeedOscEn}, 5'b11100);
      @(posedge mclk);
      watchdogReq <= 1'b0;
   endtask : wdt_pulse
   task automatic pin_pulse;
      @(posedge mclk);
      pinLowReq <= 1'b1;
      @(posedge mclk);
      pinLowReq <= 1'b0;
      look(208);
   endtask : pin_pulse
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_boot;
      run_within(512 + 10, 545);
      rd(`RSC_OFS_CTRL);
      check(d, 32'h0);
      rd(`RSC_OFS_SETTLE);
      check(d, 32'h0);
      rd(4'hc);
      check(d, 32'h0);
      $display("boot test done");
   endtask : t_boot
   task automatic t_idle;
      @(posedge mclk);
      intMask <= 8'hfe;
      irqLevel <= 8'h02;
      wr(`RSC_OFS_CTRL, 32'h1);
      rd(`RSC_OFS_STATUS);
      check(d[3:0], RSC_IDLE);
      look(20);
      check(cpuRun, 1'b0);
      @(posedge mclk);
      irqLevel <= 8'h03;
      look(3);
      check(cpuRun, 1'b1);
      wr(`RSC_OFS_CTRL, 32'h2);
      look(3);
      check(cpuRun, 1'b1);
      @(posedge mclk);
      irqLevel <= 8'h00;
      $display("idle test done");
   endtask : t_idle
   task automatic t_stop;
      for (int x = 0; x < 2; x++) begin
         wr(`RSC_OFS_SETTLE, 32'h1);
         wr(`RSC_OFS_CTRL, {29'h0, x[0], 2'b10});
         look(50);
         check({sysClkEn, cpuRun}, 2'b00);
         @(posedge mclk);
         irqLevel <= 8'h01;
         run_within(FIX + OSC_DLY + 512 * x, FIX + OSC_DLY + 512 * x + 20);
         @(posedge mclk);
         irqLevel <= 8'h00;
      end
      $display("stop test done");
   endtask : t_stop
   task automatic t_internal;
      wr(`RSC_OFS_SETTLE, 32'h3);
      @(posedge mclk);
      optByte <= 3'b010;
      wdt_pulse();
      run_within(1024 + 10, 1100);
      rd(`RSC_OFS_STATUS);
      check(d[7:4], 4'h2);
      @(posedge mclk);
      lowVoltageDetectorReq <= 1'b1;
      look(3);
      check({lowVoltageDetectorRst, sysResetOut}, 2'b01);
      @(posedge mclk);
      lowVoltageDetectorReq <= 1'b0;
      run_within(1034, 1100);
      rd(`RSC_OFS_STATUS);
      check(d[7:4], 4'h4);
      $display("internal reset test done");
   endtask : t_internal
   task automatic t_pin;
      pin_pulse();
      check(sysResetOut, 1'b1);
      run_within(0, 2000);
      @(posedge mclk);
      optByte <= 3'b100;
      wdt_pulse();
      run_within(0, 2000);
      pin_pulse();
      check(cpuRun, 1'b1);
      wdt_pulse();
      @(posedge mclk);
      pinLowReq <= 1'b1;
      look(20);
      rd(`RSC_OFS_STATUS);
      check(d[3:0], RSC_PIN_HOLD);
      look(300);
      check(sysResetOut, 1'b1);
      @(posedge mclk);
      pinLowReq <= 1'b0;
      run_within(0, 2000);
      $display("pin test done");
   endtask : t_pin
   // ----------------------------------------
   // Run
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Longest path is two stop exits, well under the limit
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         give_verdict();
      end
   end
   initial begin
      {regAddr, regWdata, regWr, regRd, pinLowReq} = '0;
      {powerOnClearReq, lowVoltageDetectorReq, watchdogReq, arst_n} = '0;
      intMask = 8'hff;
      irqLevel = 8'h00;
      optByte = 3'b001;
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      t_boot();
      t_idle();
      t_stop();
      t_internal();
      t_pin();
      give_verdict();
   end
endmodule : rsc_standby_reset_tb

// ===== rsc_timer.sv
`include "rsc_map.svh"

module rsc_timer
   import rsc_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic load,
   input wire logic [`RSC_TMR_W-1:0] loadVal,
   output logic done
);

   logic [`RSC_TMR_W-1:0] cnt_r;
   logic [`RSC_TMR_W-1:0] cnt_nxt;
   logic done_r;
   logic done_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      done_nxt = 1'b0;
      if (load) begin
         cnt_nxt = loadVal;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
         done_nxt = (cnt_r == `RSC_TMR_W'(1));
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= '0;
         done_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   assign done = done_r;

endmodule : rsc_timer
